/* common/pie_pkg.sv */
package pie_pkg;
  // ************************************************************
  // Register map and field positions
  // ************************************************************
  localparam logic [3:0] ENABLE_A_OFFSET = 4'h0;
  localparam logic [3:0] ENABLE_D_OFFSET = 4'h1;
  localparam logic [3:0] CONTROL_OFFSET = 4'h2;
  localparam logic [3:0] STATUS_OFFSET = 4'h3;
  localparam logic [3:0] MASK_OFFSET = 4'h4;
  localparam logic [3:0] PENDING_OFFSET = 4'h5;
  localparam logic [7:0] ENABLE_A_RESET = 8'h00;
  localparam logic [7:0] ENABLE_D_RESET = 8'h00;
  localparam logic [7:0] ENABLE_D_IMPL = 8'h33;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int CONTROL_MASTER_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int STATUS_REQ_RISE_BIT = 0;
  localparam int STATUS_REQ_FALL_BIT = 1;
  localparam int SOURCE_COUNT = 12;

  // Source flags from the peripherals, in enable-bit order
  typedef struct packed {
    logic [7:0] group_a;
    logic [7:0] group_d;
  } pie_flags_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pie_bus_req_t;
endpackage : pie_pkg

/* logic/pie_bus_slave.sv */
`timescale 1ns/1ps
// ************************************************************
// Register port decode
// ************************************************************
module pie_bus_slave (
  input wire pie_pkg::pie_bus_req_t req,
  output logic wr_a,
  output logic wr_d,
  output logic wr_ctrl,
  output logic wr_mask,
  output logic rd_status
);
  // Strobe decode per register
  always_comb begin
    wr_a = req.wr && (req.addr == pie_pkg::ENABLE_A_OFFSET);
    wr_d = req.wr && (req.addr == pie_pkg::ENABLE_D_OFFSET);
    wr_ctrl = req.wr && (req.addr == pie_pkg::CONTROL_OFFSET);
    wr_mask = req.wr && (req.addr == pie_pkg::MASK_OFFSET);
    rd_status = req.rd && (req.addr == pie_pkg::STATUS_OFFSET);
  end
endmodule : pie_bus_slave

/* logic/pie_gate.sv */
`timescale 1ns/1ps
// ************************************************************
// Per-source enable gating
// ************************************************************
module pie_gate #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] flags,
  input wire logic [WIDTH-1:0] enables,
  input wire logic master,
  output logic [WIDTH-1:0] pending,
  output logic request
);
  genvar i;
  // One AND gate per source
  generate
    for (i = 0; i < WIDTH; i++) begin : g_src
      assign pending[i] = flags[i] & enables[i];
    end
  endgenerate
  assign request = master & (|pending);
endmodule : pie_gate

/* logic/pie_top.sv */
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Enable A bit 6 gates conversion done interrupt.
// - Enable A bit 5 gates serial receive interrupt.
// - Enable A bit 4 gates serial transmit interrupt.
// - Enable A bit 3 gates synchronous serial interrupt.
// - Enable A bit 2 gates capture/compare one interrupt.
// - Enable A bit 1 gates second timer period match interrupt.
// - Enable A bit 0 gates first timer overflow interrupt.
// - periph_irq_req stays low unless the master peripheral enable is set; latched status bits still drive irq.
// - Enable D bit 1 gates switch controller B shutdown interrupt.
// - Enable D bit 0 gates switch controller A shutdown interrupt.
// - Enable D bits 7-6 and 3-2 ignore writes, read zero.
// - All implemented enable bits read/write and reset to zero.
module pie_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire pie_pkg::pie_flags_t flags,
  output logic [7:0] rdata,
  output logic periph_irq_req,
  output logic irq
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] peripheral_irq_enable_a_reg;
  logic [7:0] peripheral_irq_enable_d_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic req_prev_reg;
  logic wr_a, wr_d, wr_ctrl, wr_mask, rd_status;
  logic request;
  logic [7:0] events;
  logic [7:0] status_next;
  logic [7:0] rdata_next;
  pie_pkg::pie_bus_req_t bus_req;

  assign bus_req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Register strobes
  pie_bus_slave u_bus (
    .req(bus_req),
    .wr_a(wr_a),
    .wr_d(wr_d),
    .wr_ctrl(wr_ctrl),
    .wr_mask(wr_mask),
    .rd_status(rd_status)
  );

  // Source gating, A sources in the high byte
  pie_gate #(
    .WIDTH(16)
  ) u_gate (
    .flags({flags.group_a, flags.group_d}),
    .enables({peripheral_irq_enable_a_reg, peripheral_irq_enable_d_reg}),
    .master(interrupt_control_reg[pie_pkg::CONTROL_MASTER_BIT]),
    .pending(),
    .request(request)
  );

  // ************************************************************
  // Enable registers
  // ************************************************************
  // Enable A, all eight bits implemented
  always_ff @(posedge clk) begin
    if (rst) begin
      peripheral_irq_enable_a_reg <= pie_pkg::ENABLE_A_RESET;
    end else if (wr_a) begin
      peripheral_irq_enable_a_reg <= wdata;
    end
  end

  // Enable D, unimplemented bits held at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      peripheral_irq_enable_d_reg <= pie_pkg::ENABLE_D_RESET;
    end else if (wr_d) begin
      peripheral_irq_enable_d_reg <= wdata & pie_pkg::ENABLE_D_IMPL;
    end
  end

  // Interrupt control, master peripheral enable only
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_control_reg <= pie_pkg::CONTROL_RESET;
    end else if (wr_ctrl) begin
      interrupt_control_reg <= wdata & (8'h01 << pie_pkg::CONTROL_MASTER_BIT);
    end
  end

  // ************************************************************
  // Event status and mask
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      req_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= request;
    end
  end

  // Request edges as events
  always_comb begin
    events = 8'h00;
    events[pie_pkg::STATUS_REQ_RISE_BIT] = request & ~req_prev_reg;
    events[pie_pkg::STATUS_REQ_FALL_BIT] = ~request & req_prev_reg;
  end

  // Next status, a read clears but a new event still sets
  always_comb begin
    if (rd_status) begin
      status_next = events;
    end else begin
      status_next = status_reg | events;
    end
  end

  // Sticky bits, cleared by read, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= pie_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg <= pie_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= wdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      periph_irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      periph_irq_req <= request;
      irq <= |(status_next & mask_reg); // Tracks the status value it is loaded beside
    end
  end

  // Read mux
  always_comb begin
    case (addr)
      pie_pkg::ENABLE_A_OFFSET: rdata_next = peripheral_irq_enable_a_reg;
      pie_pkg::ENABLE_D_OFFSET: rdata_next = peripheral_irq_enable_d_reg;
      pie_pkg::CONTROL_OFFSET: rdata_next = interrupt_control_reg;
      pie_pkg::STATUS_OFFSET: rdata_next = status_reg;
      pie_pkg::MASK_OFFSET: rdata_next = mask_reg;
      pie_pkg::PENDING_OFFSET: rdata_next = {7'h00, request};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : pie_top

/* testbench/pie_top_sva.sv */
`timescale 1ns/1ps
// **********
// Port checker
// **********
module pie_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire pie_pkg::pie_flags_t flags,
  input wire logic [7:0] rdata,
  input wire logic periph_irq_req,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Write then read of one index
  sequence s_wr_rd(a);
    wr && addr == a ##1 rd && addr == a;
  endsequence
  a_rw_enable_a:
    assert property (s_wr_rd(pie_pkg::ENABLE_A_OFFSET) |=> rdata == $past(wdata, 2)) else $error("enable a readback");
  a_rw_enable_d:
    assert property (s_wr_rd(pie_pkg::ENABLE_D_OFFSET) |=> rdata == ($past(wdata, 2) & pie_pkg::ENABLE_D_IMPL))
    else $error("enable d readback");
  a_unimpl_zero:
    assert property (rd && addr == pie_pkg::ENABLE_D_OFFSET |=> (rdata & ~pie_pkg::ENABLE_D_IMPL) == 8'h00)
    else $error("enable d spare bits");
  a_unmapped_zero:
    assert property (rd && addr > pie_pkg::PENDING_OFFSET |=> rdata == 8'h00) else $error("unmapped read");
  a_ctrl_master_only:
    assert property (rd && addr == pie_pkg::CONTROL_OFFSET |=> (rdata & 8'hBF) == 8'h00) else $error("control bits");
  a_idle_rdata:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside read");
  a_no_flag_no_req:
    assert property ($past(flags) == '0 |-> !periph_irq_req) else $error("request without flag");
  a_reset_quiet:
    assert property ($past(rst) |-> !irq && !periph_irq_req && rdata == 8'h00) else $error("outputs after reset");
endmodule : pie_top_sva

bind pie_top pie_top_sva pie_top_sva_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .flags(flags), .rdata(rdata), .periph_irq_req(periph_irq_req), .irq(irq));

/* testbench/pie_sources.sv */
`timescale 1ns/1ps
// **********
// Peripheral event sources
// **********
module pie_sources (
  input wire logic clk,
  input wire logic [15:0] raise,
  output pie_pkg::pie_flags_t flags
);
  // Source levels follow the pattern one cycle later
  always_ff @(posedge clk) begin
    flags <= raise;
  end
endmodule : pie_sources

/* testbench/pie_top_test.sv */
`timescale 1ns/1ps
// **********
// Bench
// **********
module pie_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] raise = 16'h0000;
  pie_pkg::pie_flags_t flags;
  logic [7:0] rdata;
  logic periph_irq_req;
  logic irq;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  pie_top pie_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .flags(flags),
    .rdata(rdata), .periph_irq_req(periph_irq_req), .irq(irq));
  pie_sources pie_sources_inst (.clk(clk), .raise(raise), .flags(flags));
  // Clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles, entered just after a rising edge
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : put
  // Write then read back of one index, no gap between strobes
  task automatic put_get(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask : put_get
  task automatic get(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask : get
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic see(input logic v, input logic e);
    chk({7'h00, v}, {7'h00, e});
    @(posedge clk);
  endtask : see
  task automatic t_regs;
    get(pie_pkg::ENABLE_A_OFFSET, 8'h00);
    get(pie_pkg::ENABLE_D_OFFSET, 8'h00);
    put_get(pie_pkg::ENABLE_A_OFFSET, 8'hFF, 8'hFF);
    put_get(pie_pkg::ENABLE_A_OFFSET, 8'h5A, 8'h5A);
    put_get(pie_pkg::ENABLE_D_OFFSET, 8'hFF, 8'h33);
    put_get(pie_pkg::ENABLE_D_OFFSET, 8'hCC, 8'h00);
    put_get(4'hF, 8'hFF, 8'h00);
    get(pie_pkg::ENABLE_D_OFFSET, 8'h00);
  endtask : t_regs
  task automatic t_irq;
    put(pie_pkg::CONTROL_OFFSET, 8'hFF);
    get(pie_pkg::CONTROL_OFFSET, 8'h40);
    put(pie_pkg::ENABLE_A_OFFSET, 8'h01);
    put(pie_pkg::MASK_OFFSET, 8'h01);
    raise <= 16'h0100;
    settle;
    see(irq, 1'b1);
    get(pie_pkg::PENDING_OFFSET, 8'h01);
    get(pie_pkg::STATUS_OFFSET, 8'h01);
    settle;
    see(irq, 1'b0);
    raise <= 16'h0000;
    settle;
    see(irq, 1'b0);
    get(pie_pkg::STATUS_OFFSET, 8'h02);
  endtask : t_irq
  // Each enable gates its own source only
  task automatic t_gate;
    logic [15:0] m;
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      raise <= m;
      put(pie_pkg::ENABLE_A_OFFSET, m[15:8]);
      put(pie_pkg::ENABLE_D_OFFSET, m[7:0]);
      settle;
      see(periph_irq_req, i > 7 || pie_pkg::ENABLE_D_IMPL[i % 8]);
      put(pie_pkg::ENABLE_A_OFFSET, ~m[15:8]);
      put(pie_pkg::ENABLE_D_OFFSET, ~m[7:0]);
      settle;
      see(periph_irq_req, 1'b0);
    end
    put(pie_pkg::CONTROL_OFFSET, 8'h00);
    raise <= 16'hFFFF;
    settle;
    see(periph_irq_req, 1'b0);
  endtask : t_gate
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_irq;
    t_gate;
    results;
  end
endmodule : pie_top_test
